// [bmd_consts.svh]
// constants for the banked memory map decoder: offsets, field positions, vectors, reset values
`ifndef BMD_CONSTS_SVH
`define BMD_CONSTS_SVH

// program side
`define BMD_PC_W 13
`define BMD_FETCH_W 11
`define BMD_RESET_VECTOR 13'h0000
`define BMD_IRQ_VECTOR 13'h0004
`define BMD_SMALL_PROG_MASK 13'h03ff
`define BMD_LARGE_PROG_MASK 13'h07ff

// data side layout
`define BMD_SFR_COUNT 7'h20
`define BMD_INDIRECT_OFS 7'h00
`define BMD_STATUS_OFS 7'h03
`define BMD_POINTER_OFS 7'h04
`define BMD_LARGE_RAM_BASE 7'h20
`define BMD_RAM_DEPTH 128
`define BMD_RAM_AW 7

// core status fields
`define BMD_STATUS_BANK_BIT 5
`define BMD_STATUS_RSV_HIGH_BIT 6
`define BMD_STATUS_RSV_IND_BIT 7
`define BMD_STATUS_RESET 8'h00
`define BMD_POINTER_RESET 8'h00

// register bus word indices; byte address is four times the index
`define BMD_AV_IDX_INDIRECT 6'h00
`define BMD_AV_IDX_STATUS 6'h03
`define BMD_AV_IDX_POINTER 6'h04
`define BMD_AV_IDX_PC_VIEW 6'h08
`define BMD_AV_IDX_INFO 6'h09

`endif

// [bmd_pkg.sv]
// types shared by the banked memory map decoder files
package bmd_pkg;

	// one data access from the core: address field is the 7-bit instruction operand
	typedef struct packed
	{
		logic valid;
		logic write;
		logic [6:0] addr7;
		logic [7:0] wdata;
	} bmd_core_req_s;

	// answer to a core read
	typedef struct packed
	{
		logic valid;
		logic [7:0] rdata;
	} bmd_core_rsp_s;

	// where a decoded location lives
	typedef enum logic [1:0]
	{
		SRC_ZERO,
		SRC_RAM,
		SRC_STATUS,
		SRC_POINTER
	} bmd_src_e;

	typedef struct packed
	{
		bmd_src_e src;
		logic [6:0] ram_idx;
	} bmd_dec_s;

	typedef enum logic [1:0]
	{
		AV_IDLE,
		AV_WAIT,
		AV_DONE
	} bmd_av_state_e;

endpackage

// [bmd_ram.sv]
// general purpose static ram of the data space, one port, registered read data
`timescale 1ns/1ps
`include "bmd_consts.svh"
module bmd_ram
	import bmd_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// access port
	input wire logic we_i,
	input wire logic [6:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);

	logic [7:0] mem [0:`BMD_RAM_DEPTH-1];
	logic [7:0] rdata_reg;

	// storage has no reset; contents are undefined at power up like real sram
	always_ff @(posedge clk_sys_i)
	begin
		if (we_i)
			mem[addr_i] <= wdata_i;
	end

	// read returns the old word when written in the same cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= mem[addr_i];
	end

	assign rdata_o = rdata_reg;

endmodule // bmd_ram

// [bmd_decoder.sv]
// banked memory map decoder: program counter wrap and vectors, two-bank data space, register bus
//
// How it works
// RL1 - program counter is 13 bits wide, covering an 8K word program space
// RL2 - small variant implements only program words 0000h to 03FFh
// RL3 - large variant implements only program words 0000h to 07FFh
// RL4 - addresses above the implemented area wrap by dropping upper bits, never fault
// RL5 - fetch starts at 0000h after reset
// RL6 - taking an interrupt sends fetch to 0004h
// RL7 - two data banks, lowest 32 locations of each are special registers
// RL8 - small variant has ram at bank 0 locations 40h to 7Fh
// RL9 - large variant has ram at 20h to 7Fh and bank 1 A0h to BFh
// RL10 - bank 1 F0h to FFh reach the same cells as 70h to 7Fh
// RL11 - unimplemented data locations read as zero
// RL12 - bank select status bit: 0 picks bank 0, 1 picks bank 1
// RL13 - software keeps both reserved bank extension status bits at zero
// RL14 - ram is 64 bytes in the small variant, 128 bytes in the large
// RL15 - every data register reachable directly or through the indirect pointer
// RL16 - direct address is the bank select bit in front of the 7-bit field
// RL17 - status, pointer and indirect port are one cell seen from both banks
`timescale 1ns/1ps
`include "bmd_consts.svh"
module bmd_decoder
	import bmd_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// program counter control from the core
	input wire logic pc_inc_i,
	input wire logic pc_load_i,
	input wire logic [12:0] pc_load_addr_i,
	input wire logic irq_take_i,
	// program counter and physical fetch address
	output logic [12:0] pc_o,
	output logic [10:0] fetch_addr_o,
	// core data access
	input wire bmd_core_req_s core_req_i,
	output bmd_core_rsp_s core_rsp_o,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	// program side state
	logic [12:0] pc_reg;
	logic [12:0] pc_next;
	logic [10:0] fetch_reg;
	logic [12:0] wrap_addr;

	// core register cells
	logic [7:0] status_reg;
	logic [7:0] pointer_reg;

	// access pipeline
	logic acc_valid;
	logic acc_write;
	logic acc_core;
	logic [7:0] acc_addr;
	logic [7:0] acc_wdata;
	logic [15:0] acc_view;
	logic acc_view_sel;
	bmd_dec_s acc_dec;
	logic s1_valid_reg;
	logic s1_core_reg;
	bmd_src_e s1_src_reg;
	logic [15:0] s1_view_reg;
	logic s1_view_sel_reg;
	logic [7:0] s1_value;
	logic [7:0] ram_rdata;
	logic ram_we;

	// register bus side
	bmd_av_state_e av_state_reg;
	logic av_go;
	logic [5:0] av_idx;
	logic [31:0] readdata_reg;
	logic waitrequest_reg;
	bmd_core_rsp_s core_rsp_reg;

	// map a full 8-bit data address onto its storage
	function automatic bmd_dec_s decode(input logic [7:0] a);
		bmd_dec_s d;
		d.src = SRC_ZERO;
		d.ram_idx = 7'h00;
		if (a[6:0] < `BMD_SFR_COUNT) // RL7
		begin
			// same cell regardless of bank
			if (a[6:0] == `BMD_STATUS_OFS) // RL17
				d.src = SRC_STATUS;
			else if (a[6:0] == `BMD_POINTER_OFS) // RL17
				d.src = SRC_POINTER;
		end
		else if (LARGE_VARIANT)
		begin
			if (!a[7])
			begin
				d.src = SRC_RAM; // RL9
				d.ram_idx = a[6:0] - `BMD_LARGE_RAM_BASE; // RL14
			end
			else if (a[6:5] == 2'h1)
			begin
				d.src = SRC_RAM; // RL9
				d.ram_idx = {2'h3, a[4:0]};
			end
			else if (a[6:4] == 3'h7)
			begin
				d.src = SRC_RAM; // RL10
				d.ram_idx = {3'h5, a[3:0]};
			end
		end
		else
		begin
			if (!a[7] && a[6])
			begin
				d.src = SRC_RAM; // RL8
				d.ram_idx = {1'h0, a[5:0]}; // RL14
			end
			else if (a[7] && a[6:4] == 3'h7)
			begin
				d.src = SRC_RAM; // RL10
				d.ram_idx = {3'h3, a[3:0]};
			end
		end
		return d;
	endfunction

	// next counter value: reset, then interrupt, then load, then step
	always_comb
	begin
		pc_next = pc_reg;
		if (irq_take_i)
			pc_next = `BMD_IRQ_VECTOR; // RL6
		else if (pc_load_i)
			pc_next = pc_load_addr_i;
		else if (pc_inc_i)
			pc_next = pc_reg + 13'h0001; // RL1
	end

	// upper bits are dropped so a stray jump lands inside the array
	assign wrap_addr = pc_next & (LARGE_VARIANT ? `BMD_LARGE_PROG_MASK : `BMD_SMALL_PROG_MASK); // RL2 RL3 RL4

	// program counter and fetch address register
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pc_reg <= `BMD_RESET_VECTOR; // RL5
			fetch_reg <= 11'h000; // RL5
		end
		else
		begin
			pc_reg <= pc_next;
			fetch_reg <= wrap_addr[10:0];
		end
	end

	// bus gets a slot only when the core is quiet; core never waits
	assign av_idx = avs_address_i[7:2];
	assign av_go = (av_state_reg == AV_IDLE) && (avs_read_i || avs_write_i) && !core_req_i.valid;

	// select the one access of this cycle and form its full address
	always_comb
	begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_core = 1'b0;
		acc_addr = 8'h00;
		acc_wdata = 8'h00;
		acc_view = 16'h0000;
		acc_view_sel = 1'b0;
		if (core_req_i.valid)
		begin
			acc_valid = 1'b1;
			acc_core = 1'b1;
			acc_write = core_req_i.write;
			acc_wdata = core_req_i.wdata;
			// reserved status bits take no part in bank choice
			acc_addr = {status_reg[`BMD_STATUS_BANK_BIT], core_req_i.addr7}; // RL12 RL16 RL13
			if (core_req_i.addr7 == `BMD_INDIRECT_OFS)
				acc_addr = pointer_reg; // RL15 RL17
		end
		else if (av_go)
		begin
			acc_valid = 1'b1;
			acc_write = avs_write_i && avs_byteenable_i[0];
			acc_wdata = avs_writedata_i[7:0];
			// read-only and unmapped words take the view path, so their writes are dropped
			acc_view_sel = 1'b1;
			case (av_idx)
				`BMD_AV_IDX_INDIRECT: {acc_view_sel, acc_addr} = {1'b0, pointer_reg}; // RL15
				`BMD_AV_IDX_STATUS: {acc_view_sel, acc_addr} = {2'b00, `BMD_STATUS_OFS};
				`BMD_AV_IDX_POINTER: {acc_view_sel, acc_addr} = {2'b00, `BMD_POINTER_OFS};
				`BMD_AV_IDX_PC_VIEW: acc_view = {3'h0, pc_reg};
				`BMD_AV_IDX_INFO: acc_view = {15'h0000, LARGE_VARIANT};
				default: acc_view = 16'h0000;
			endcase
		end
	end

	// pointer at an indirect port location decodes as zero, so no loop
	assign acc_dec = decode(acc_addr);
	assign ram_we = acc_valid && acc_write && (acc_dec.src == SRC_RAM) && !acc_view_sel;

	bmd_ram u_ram
	(
		.clk_sys_i (clk_sys_i),
		.rst_i (rst_i),
		.we_i (ram_we),
		.addr_i (acc_dec.ram_idx),
		.wdata_i (acc_wdata),
		.rdata_o (ram_rdata)
	);

	// status cell, shared by both banks
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			status_reg <= `BMD_STATUS_RESET;
		else if (acc_valid && acc_write && !acc_view_sel && acc_dec.src == SRC_STATUS)
			status_reg <= acc_wdata; // RL17
	end

	// indirect pointer cell, shared by both banks
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			pointer_reg <= `BMD_POINTER_RESET;
		else if (acc_valid && acc_write && !acc_view_sel && acc_dec.src == SRC_POINTER)
			pointer_reg <= acc_wdata; // RL17
	end

	// stage one: remember source while the ram read completes
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			s1_valid_reg <= 1'b0;
			s1_core_reg <= 1'b0;
			s1_src_reg <= SRC_ZERO;
			s1_view_reg <= 16'h0000;
			s1_view_sel_reg <= 1'b0;
		end
		else
		begin
			s1_valid_reg <= acc_valid;
			s1_core_reg <= acc_core;
			s1_src_reg <= acc_dec.src;
			s1_view_reg <= acc_view;
			s1_view_sel_reg <= acc_view_sel;
		end
	end

	// status and pointer are sampled late, so a write just before is seen
	always_comb
	begin
		case (s1_src_reg)
			SRC_RAM: s1_value = ram_rdata;
			SRC_STATUS: s1_value = status_reg;
			SRC_POINTER: s1_value = pointer_reg;
			default: s1_value = 8'h00; // RL11
		endcase
	end

	// answer to the core two edges after its request
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			core_rsp_reg <= '0;
		else
		begin
			core_rsp_reg.valid <= s1_valid_reg && s1_core_reg;
			if (s1_valid_reg && s1_core_reg)
				core_rsp_reg.rdata <= s1_value;
		end
	end

	// bus slave sequencing
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			av_state_reg <= AV_IDLE;
		else
		begin
			case (av_state_reg)
				AV_IDLE: if (av_go) av_state_reg <= AV_WAIT;
				AV_WAIT: av_state_reg <= AV_DONE;
				AV_DONE: av_state_reg <= AV_IDLE;
				default: av_state_reg <= AV_IDLE;
			endcase
		end
	end

	// waitrequest drops for exactly the done cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			waitrequest_reg <= 1'b1;
		else
			waitrequest_reg <= (av_state_reg != AV_WAIT);
	end

	// read data, narrow values in the low bits
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			readdata_reg <= 32'h00000000;
		else if (av_state_reg == AV_WAIT)
		begin
			if (s1_view_sel_reg)
				readdata_reg <= {16'h0000, s1_view_reg};
			else
				readdata_reg <= {24'h000000, s1_value};
		end
	end

	// outputs straight from flip-flops
	assign pc_o = pc_reg;
	assign fetch_addr_o = fetch_reg;
	assign core_rsp_o = core_rsp_reg;
	assign avs_readdata_o = readdata_reg;
	assign avs_waitrequest_o = waitrequest_reg;

endmodule // bmd_decoder

// [bmd_decoder_properties.sv]
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module bmd_decoder_properties
	import bmd_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// program counter
	input wire logic pc_inc_i,
	input wire logic pc_load_i,
	input wire logic [12:0] pc_load_addr_i,
	input wire logic irq_take_i,
	input wire logic [12:0] pc_o,
	input wire logic [10:0] fetch_addr_o,
	// data and register bus
	input wire bmd_core_req_s core_req_i,
	input wire bmd_core_rsp_s core_rsp_o,
	input wire logic avs_read_i,
	input wire logic avs_waitrequest_o
);
	// one domain, so one clock and one disable for all
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	AST_RESET_PC: assert property ($fell(rst_i) |-> pc_o == 13'h0000 && fetch_addr_o == 11'h000)
		else $error("pc not at zero after reset");
	AST_IRQ_VEC: assert property (irq_take_i |=> pc_o == 13'h0004)
		else $error("interrupt did not vector");
	AST_LOAD: assert property (pc_load_i && !irq_take_i |=> pc_o == $past(pc_load_addr_i))
		else $error("jump target lost");
	AST_STEP: assert property (pc_inc_i && !pc_load_i && !irq_take_i |=> pc_o == $past(pc_o) + 13'h0001)
		else $error("pc step wrong");
	AST_WRAP: assert property (fetch_addr_o == (pc_o[10:0] & (LARGE_VARIANT ? 11'h7ff : 11'h3ff)))
		else $error("fetch address not wrapped");
	AST_RSP_LAT: assert property (core_req_i.valid |-> ##2 core_rsp_o.valid)
		else $error("core answer late");
	AST_RSP_CAUSE: assert property (core_rsp_o.valid |-> $past(core_req_i.valid, 2))
		else $error("core answer without request");
	AST_SFR_ZERO: assert property (core_req_i.valid && !core_req_i.write && core_req_i.addr7 == 7'h01
		|-> ##2 core_rsp_o.rdata == 8'h00)
		else $error("peripheral slot not zero");

	// main scenarios reached
	cover property (irq_take_i);
	cover property (core_rsp_o.valid && core_rsp_o.rdata != 8'h00);
	cover property (avs_read_i && !avs_waitrequest_o);
endmodule // bmd_decoder_properties

// [bmd_core_model.sv]
// core-side model: data accesses and program counter requests
`timescale 1ns/1ps
module bmd_core_model
	import bmd_pkg::*;
(
	// clock
	input wire logic clk_sys_i,
	// towards the decoder
	output bmd_core_req_s core_req_o,
	output logic pc_inc_o,
	output logic pc_load_o,
	output logic [12:0] pc_load_addr_o,
	output logic irq_take_o,
	// answer
	input wire bmd_core_rsp_s core_rsp_i
);
	// idle core at time zero
	initial
	begin
		core_req_o = '0;
		{pc_inc_o, pc_load_o, pc_load_addr_o, irq_take_o} = '0;
	end

	// one access, valid a single cycle; answer stands in the second cycle after the request
	// a missing answer returns unknown so it cannot match
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		core_req_o <= {1'b1, w, a, d};
		@(posedge clk_sys_i);
		core_req_o <= '0;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		q = core_rsp_i.valid ? core_rsp_i.rdata : 8'hxx;
	endtask

	// one cycle of program counter control
	task automatic pc_req(input logic inc, input logic ld, input logic [12:0] a, input logic irq);
		@(posedge clk_sys_i);
		{pc_inc_o, pc_load_o, pc_load_addr_o, irq_take_o} <= {inc, ld, a, irq};
		@(posedge clk_sys_i);
		{pc_inc_o, pc_load_o, irq_take_o} <= 3'b000;
		@(negedge clk_sys_i);
	endtask
endmodule // bmd_core_model

// [tb_banked_memory_map_decoder.sv]
// top-level testbench for the banked memory map decoder
`timescale 1ns/1ps
module tb_banked_memory_map_decoder;
	import bmd_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = '0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o, r;
	logic avs_waitrequest_o, pc_inc_i, pc_load_i, irq_take_i;
	logic [12:0] pc_load_addr_i, pc_o;
	logic [10:0] fetch_addr_o;
	logic [7:0] q;
	bmd_core_req_s core_req_i;
	bmd_core_rsp_s core_rsp_o;
	int fail_count = 0;
	int checks = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	bmd_decoder #(.LARGE_VARIANT(1'b1)) u_dut (.clk_sys_i, .rst_i, .pc_inc_i, .pc_load_i, .pc_load_addr_i,
		.irq_take_i, .pc_o, .fetch_addr_o, .core_req_i, .core_rsp_o, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);
	bmd_core_model u_core (.clk_sys_i, .core_req_o(core_req_i), .pc_inc_o(pc_inc_i), .pc_load_o(pc_load_i),
		.pc_load_addr_o(pc_load_addr_i), .irq_take_o(irq_take_i), .core_rsp_i(core_rsp_o));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// bus cycle held until waitrequest is sampled low at a rising edge; read data taken at that edge
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("pc", 13'h0000, pc_o);
		chk("fetch", 11'h000, fetch_addr_o);
		av(1'b0, 8'h0c, '0, 4'hf, r);
		chk("status", 32'h0, r);
		av(1'b0, 8'h10, '0, 4'hf, r);
		chk("pointer", 32'h0, r);
		av(1'b1, 8'h3c, 32'h5a, 4'hf, r);
		av(1'b0, 8'h3c, '0, 4'hf, r);
		chk("unmapped", 32'h0, r);
		av(1'b1, 8'h0c, 32'h20, 4'he, r);
		av(1'b0, 8'h0c, '0, 4'hf, r);
		chk("status lane", 32'h0, r);
		av(1'b0, 8'h24, '0, 4'hf, r);
		chk("info", 32'h1, r);
		$display("test registers done");
		u_core.pc_req(1'b0, 1'b1, 13'h1805, 1'b0);
		chk("pc load", 13'h1805, pc_o);
		chk("fetch wrap", 11'h005, fetch_addr_o);
		u_core.pc_req(1'b1, 1'b1, 13'h0100, 1'b1);
		chk("irq vector", 13'h0004, pc_o);
		chk("fetch irq", 11'h004, fetch_addr_o);
		u_core.pc_req(1'b0, 1'b1, 13'h07ff, 1'b0);
		chk("fetch 7ffh", 11'h7ff, fetch_addr_o);
		u_core.pc_req(1'b1, 1'b0, 13'h0000, 1'b0);
		chk("pc step", 13'h0800, pc_o);
		chk("fetch top", 11'h000, fetch_addr_o);
		av(1'b0, 8'h20, '0, 4'hf, r);
		chk("pc view", 32'h0800, r);
		$display("test program counter done");
		u_core.acc(1'b1, 7'h70, 8'ha5, q);
		u_core.acc(1'b1, 7'h20, 8'h11, q);
		av(1'b1, 8'h0c, 32'h20, 4'hf, r);
		u_core.acc(1'b0, 7'h70, 8'h00, q);
		chk("shared F0h", 8'ha5, q);
		u_core.acc(1'b1, 7'h20, 8'hc3, q);
		u_core.acc(1'b0, 7'h40, 8'h00, q);
		chk("gap C0h", 8'h00, q);
		u_core.acc(1'b0, 7'h03, 8'h00, q);
		chk("status bank 1", 8'h20, q);
		u_core.acc(1'b0, 7'h01, 8'h00, q);
		chk("sfr 81h", 8'h00, q);
		av(1'b1, 8'h0c, 32'h00, 4'hf, r);
		u_core.acc(1'b0, 7'h20, 8'h00, q);
		chk("bank 0 20h", 8'h11, q);
		u_core.acc(1'b1, 7'h04, 8'ha0, q);
		u_core.acc(1'b0, 7'h00, 8'h00, q);
		chk("indirect A0h", 8'hc3, q);
		av(1'b0, 8'h10, '0, 4'hf, r);
		chk("pointer shared", 32'ha0, r);
		av(1'b0, 8'h00, '0, 4'hf, r);
		chk("bus indirect", 32'hc3, r);
		$display("test data banks done");
		// second reset in mid-run: counter and pointer must come back to their reset values
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(negedge clk_sys_i);
		chk("pc after reset", 13'h0000, pc_o);
		av(1'b0, 8'h10, '0, 4'hf, r);
		chk("pointer after reset", 32'h0, r);
		$display("test mid reset done");
		stop_test();
	end

	// hang guard, well beyond the hundred or so cycles the tests need
	initial
	begin
		repeat (3000) @(posedge clk_sys_i);
		fail_count++;
		stop_test();
	end
endmodule // tb_banked_memory_map_decoder

bind bmd_decoder bmd_decoder_properties #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (.clk_sys_i, .rst_i, .pc_inc_i,
	.pc_load_i, .pc_load_addr_i, .irq_take_i, .pc_o, .fetch_addr_o, .core_req_i, .core_rsp_o, .avs_read_i,
	.avs_waitrequest_o);
